/* File: hw/hbc_pkg.sv */
// Shared constants and types for the host bus control port
package hbc_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_NS      = 4;
  localparam int LCLK_MAX_MHZ       = 50;
  localparam int LCLK_MIN_PERIOD_NS = 1000 / LCLK_MAX_MHZ;
  localparam int LCLK_PERIOD_NS     = 64;
  localparam int LCLK_HALF_CYC      = (LCLK_PERIOD_NS / 2 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [3:0] LCLK_HALF_CNT = 4'(LCLK_HALF_CYC - 1);
  localparam logic [3:0] SETTLE_CNT    = 4'h7;
  localparam logic [3:0] EISA_WAIT_CNT = 4'h3;
  // Async ready is trusted only after both pin filters have had time to pass it
  localparam logic [3:0] ASYNC_WAIT_CNT = 4'hc;

  // ----------------------------------------------------------------
  // Widths and decode
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 12;
  localparam int BASE_W  = 8;
  localparam int EVENT_W = 8;
  localparam logic [3:0] BASE_LOW_NIBBLE = 4'h0;

  // ----------------------------------------------------------------
  // Device pin sample vector
  // ----------------------------------------------------------------
  localparam int PIN_W    = 21;
  localparam int P_BCLK   = 0;
  localparam int P_LBS_N  = 1;
  localparam int P_RR_N   = 2;
  localparam int P_RD_N   = 3;
  localparam int P_WR_N   = 4;
  localparam int P_AQ     = 5;
  localparam int P_ADS_N  = 6;
  localparam int P_CYC_N  = 7;
  localparam int P_WNR    = 8;
  localparam int P_ADDR   = 9;
  localparam logic [PIN_W-1:0] PIN_RST = 21'h0000ff;

  // Host side sample vector
  localparam int HS_W    = 3;
  localparam int H_ASYNC_RDY = 0;
  localparam int H_SRDY_N = 1;
  localparam int H_IRQ   = 2;
  localparam logic [HS_W-1:0] HS_RST = 3'h3;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HBC_D_IDLE = 2'b00,
    HBC_D_BUSY = 2'b01,
    HBC_D_DONE = 2'b11,
    HBC_D_END  = 2'b10
  } hbc_dev_state_t;

  typedef enum logic [2:0] {
    HBC_H_IDLE    = 3'b000,
    HBC_H_ADDR    = 3'b001,
    HBC_H_LATCH   = 3'b011,
    HBC_H_WAIT    = 3'b010,
    HBC_H_RELEASE = 3'b110
  } hbc_host_state_t;

endpackage : hbc_pkg

/* File: hw/hbc_link_if.sv */
// Pin-level link between the host bus controller and the device port
`timescale 1ns/1ns
interface hbc_link_if;
  import hbc_pkg::*;

  logic              bus_clk;
  logic              local_bus_select_n;
  logic              ready_return_n;
  logic              read_strobe_n;
  logic              write_strobe_n;
  logic              address_qualifier;
  logic [ADDR_W-1:0] upper_address_bits;
  logic              address_latch_strobe_n;
  logic              sync_cycle_n;
  logic              write_not_read;
  logic              async_ready_o;
  logic              async_ready_oe;
  logic              async_ready_out;
  logic              sync_ready_n;
  logic              host_irq;
  logic              local_device_hit_n;

  // Open-drain line with pull-up
  assign async_ready_out = async_ready_oe ? async_ready_o : 1'b1;

  modport device (
    input  bus_clk, local_bus_select_n, ready_return_n, read_strobe_n, write_strobe_n,
    input  address_qualifier, upper_address_bits, address_latch_strobe_n, sync_cycle_n, write_not_read,
    output async_ready_o, async_ready_oe, sync_ready_n, host_irq, local_device_hit_n
  );

  modport host (
    output bus_clk, local_bus_select_n, ready_return_n, read_strobe_n, write_strobe_n,
    output address_qualifier, upper_address_bits, address_latch_strobe_n, sync_cycle_n, write_not_read,
    input  async_ready_out, sync_ready_n, host_irq, local_device_hit_n
  );

endinterface : hbc_link_if

/* File: hw/hbc_device.sv */
// Device end of the host bus control port
//
// Contract
// - select input low picks local-bus, else EISA
// - bus clock never above 50 MHz
// - host holds bus clock high when asynchronous
// - async ready held low until access completes
// - async ready release timed by device clock
// - sync ready high, falling edge marks completion
// - sync read finishes only after ready return
// - interrupt high on any enabled status event
// - hit when qualifier low and address matches base
// - hit decode combinational from unlatched pins
// - host frames async access with read/write strobe
// - decode only while address qualifier low
// - address and qualifier captured on strobe rise
// - host asserts cycle one/two clocks before data
// - write-not-read high writes, low reads
`timescale 1ns/1ns
module hbc_device
  import hbc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  hbc_link_if.device              link,
  input  wire logic [BASE_W-1:0]  base_address_high,
  input  wire logic [EVENT_W-1:0] irq_events,
  input  wire logic [EVENT_W-1:0] irq_enable,
  input  wire logic               acc_done,
  output logic                    acc_start,
  output logic                    acc_write,
  output logic                    acc_sync,
  output logic [ADDR_W-1:0]       acc_address,
  output logic                    mode_local_bus
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin crosses three stages; a bit only changes once the
  // second and third stages agree, which also rejects single glitches.
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_f;
  logic [PIN_W-1:0] pin_prev;
  wire  [PIN_W-1:0] pin_raw;
  wire  [PIN_W-1:0] next_pin_f;

  assign pin_raw = {link.upper_address_bits, link.write_not_read, link.sync_cycle_n,
                    link.address_latch_strobe_n, link.address_qualifier, link.write_strobe_n,
                    link.read_strobe_n, link.ready_return_n, link.local_bus_select_n, link.bus_clk};
  assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1   <= PIN_RST;
      pin_s2   <= PIN_RST;
      pin_s3   <= PIN_RST;
      pin_f    <= PIN_RST;
      pin_prev <= PIN_RST;
    end
    else
    begin
      pin_s1   <= pin_raw;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_f    <= next_pin_f;
      pin_prev <= pin_f;
    end
  end

  wire              f_bclk  = pin_f[P_BCLK];
  wire              f_lbs_n = pin_f[P_LBS_N];
  wire              f_rr_n  = pin_f[P_RR_N];
  wire              f_rd_n  = pin_f[P_RD_N];
  wire              f_wr_n  = pin_f[P_WR_N];
  wire              f_aq    = pin_f[P_AQ];
  wire              f_cyc_n = pin_f[P_CYC_N];
  wire              f_wnr   = pin_f[P_WNR];
  wire [ADDR_W-1:0] f_addr  = pin_f[P_ADDR +: ADDR_W];
  wire              clk_rise = pin_f[P_BCLK] & ~pin_prev[P_BCLK];
  wire              ads_rise = pin_f[P_ADS_N] & ~pin_prev[P_ADS_N];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // The hit output must stay a pure decode of the pins: it may glitch
  // while the address settles, the host qualifies it with its strobes.
  wire [ADDR_W-1:0] base_match = {base_address_high, BASE_LOW_NIBBLE};
  wire              pin_hit    = ~link.address_qualifier & (link.upper_address_bits == base_match);

  assign link.local_device_hit_n = ~pin_hit;

  logic [ADDR_W-1:0] lat_addr;
  logic              lat_aq;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lat_addr <= '0;
      lat_aq   <= 1'b1;
    end
    else if (ads_rise)
    begin
      lat_addr <= f_addr;
      lat_aq   <= f_aq;
    end
  end

  wire lat_hit = ~lat_aq & (lat_addr == base_match);

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  hbc_dev_state_t state;
  hbc_dev_state_t next_state;
  logic           is_sync;
  logic           srdy_n;
  logic           stretch_oe;

  // Bus clock held high is what marks an asynchronous host
  wire async_go = lat_hit & f_bclk & (~f_rd_n | ~f_wr_n);
  wire sync_go  = lat_hit & clk_rise & ~f_cyc_n;
  wire start    = (state == HBC_D_IDLE) & (sync_go | async_go);
  wire strobes_idle = f_rd_n & f_wr_n;
  // In EISA mode there is no ready handshake, so completion is armed at once
  wire sync_armed = ~mode_local_bus | ~srdy_n;
  wire sync_finish = clk_rise & sync_armed & (acc_write | ~f_rr_n);

  always_comb
  begin
    next_state = state;
    case (state)
      HBC_D_IDLE:
        if (start)
          next_state = HBC_D_BUSY;
      HBC_D_BUSY:
        if (acc_done)
          next_state = HBC_D_DONE;
      HBC_D_DONE:
        if (is_sync ? sync_finish : strobes_idle)
          next_state = is_sync ? HBC_D_END : HBC_D_IDLE;
      HBC_D_END:
        if (f_cyc_n)
          next_state = HBC_D_IDLE;
      default:
        next_state = HBC_D_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= HBC_D_IDLE;
    else
      state <= next_state;
  end

  // Mode follows the select pin only between accesses
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_local_bus <= 1'b0;
    else if (state == HBC_D_IDLE)
      mode_local_bus <= ~f_lbs_n;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_start   <= 1'b0;
      acc_write   <= 1'b0;
      acc_sync    <= 1'b0;
      acc_address <= '0;
      is_sync     <= 1'b0;
    end
    else
    begin
      acc_start <= start;
      if (start)
      begin
        is_sync     <= sync_go;
        acc_sync    <= sync_go;
        acc_write   <= sync_go ? f_wnr : ~f_wr_n;
        acc_address <= lat_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ready outputs
  // ----------------------------------------------------------------
  // The async release is taken straight from the core's done on the
  // device clock, so the host must resynchronise it.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      stretch_oe <= 1'b0;
    else if (start & async_go & ~sync_go)
      stretch_oe <= 1'b1;
    else if (acc_done)
      stretch_oe <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      srdy_n <= 1'b1;
    else if (state != HBC_D_DONE)
      srdy_n <= 1'b1;
    else if (is_sync & mode_local_bus & clk_rise)
      srdy_n <= sync_finish;
  end

  assign link.async_ready_o  = 1'b0;
  assign link.async_ready_oe = stretch_oe;
  assign link.sync_ready_n   = srdy_n;

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic irq;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_events & irq_enable);
  end

  assign link.host_irq = irq;

endmodule : hbc_device

/* File: hw/hbc_host.sv */
// Host end: bus clock generator and access sequencer for the device port
`timescale 1ns/1ns
module hbc_host
  import hbc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  hbc_link_if.host               link,
  input  wire logic              host_mode_async,
  input  wire logic              host_mode_local_bus,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_write,
  input  wire logic              cmd_sync,
  input  wire logic [ADDR_W-1:0] cmd_address,
  output logic                   cmd_done,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  logic       bclk;
  logic [3:0] half_cnt;
  wire        half_end  = (half_cnt == LCLK_HALF_CNT);
  wire        lclk_rise = half_end & ~bclk & ~host_mode_async;
  wire        lclk_fall = half_end & bclk & ~host_mode_async;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bclk     <= 1'b1;
      half_cnt <= '0;
    end
    else if (host_mode_async)
    begin
      bclk     <= 1'b1;
      half_cnt <= '0;
    end
    else
    begin
      half_cnt <= half_end ? 4'h0 : half_cnt + 4'h1;
      if (half_end)
        bclk <= ~bclk;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [HS_W-1:0] in_s1;
  logic [HS_W-1:0] in_s2;
  logic [HS_W-1:0] in_s3;
  logic [HS_W-1:0] in_f;
  wire  [HS_W-1:0] in_raw = {link.host_irq, link.sync_ready_n, link.async_ready_out};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_s1 <= HS_RST;
      in_s2 <= HS_RST;
      in_s3 <= HS_RST;
      in_f  <= HS_RST;
    end
    else
    begin
      in_s1 <= in_raw;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      in_f  <= (in_s2 & in_s3) | (in_f & (in_s2 ^ in_s3));
    end
  end

  assign irq = in_f[H_IRQ];

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  hbc_host_state_t   state;
  logic [3:0]        wait_cnt;
  logic              op_write;
  logic              op_sync;
  logic              aq;
  logic              ads_n;
  logic              rd_n;
  logic              wr_n;
  logic              cyc_n;
  logic              wnr;
  logic              rr_n;
  logic [ADDR_W-1:0] addr;

  wire cnt_end    = (wait_cnt == SETTLE_CNT);
  // Shorter than the round trip through both filters, the old ready level would end the access
  wire async_end  = (wait_cnt == ASYNC_WAIT_CNT);
  wire eisa_end   = (wait_cnt == EISA_WAIT_CNT);
  wire sync_seen  = host_mode_local_bus ? ~in_f[H_SRDY_N] : eisa_end;

  assign cmd_ready = (state == HBC_H_IDLE);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= HBC_H_IDLE;
      wait_cnt <= '0;
      op_write <= 1'b0;
      op_sync  <= 1'b0;
      aq       <= 1'b1;
      ads_n    <= 1'b1;
      rd_n     <= 1'b1;
      wr_n     <= 1'b1;
      cyc_n    <= 1'b1;
      wnr      <= 1'b0;
      rr_n     <= 1'b1;
      addr     <= '0;
      cmd_done <= 1'b0;
    end
    else
    begin
      cmd_done <= 1'b0;
      case (state)
        HBC_H_IDLE:
          if (cmd_valid)
          begin
            op_write <= cmd_write;
            op_sync  <= cmd_sync & ~host_mode_async;
            addr     <= cmd_address;
            aq       <= 1'b0;
            ads_n    <= 1'b0;
            wait_cnt <= '0;
            state    <= HBC_H_ADDR;
          end
        HBC_H_ADDR:
          begin
            wait_cnt <= wait_cnt + 4'h1;
            if (cnt_end)
            begin
              ads_n    <= 1'b1;
              wait_cnt <= '0;
              state    <= HBC_H_LATCH;
            end
          end
        HBC_H_LATCH:
          begin
            if (!cnt_end)
              wait_cnt <= wait_cnt + 4'h1;
            else if (!op_sync)
            begin
              rd_n     <= op_write;
              wr_n     <= ~op_write;
              wait_cnt <= '0;
              state    <= HBC_H_WAIT;
            end
            else if (lclk_fall)
            begin
              cyc_n    <= 1'b0;
              wnr      <= op_write;
              wait_cnt <= '0;
              state    <= HBC_H_WAIT;
            end
          end
        HBC_H_WAIT:
          if (!op_sync)
          begin
            if (!async_end)
              wait_cnt <= wait_cnt + 4'h1;
            else if (in_f[H_ASYNC_RDY])
            begin
              rd_n     <= 1'b1;
              wr_n     <= 1'b1;
              aq       <= 1'b1;
              cmd_done <= 1'b1;
              state    <= HBC_H_IDLE;
            end
          end
          else if (lclk_rise)
          begin
            wait_cnt <= wait_cnt + 4'h1;
            if (sync_seen)
            begin
              rr_n  <= op_write;
              state <= HBC_H_RELEASE;
            end
          end
        HBC_H_RELEASE:
          if (lclk_rise)
          begin
            cyc_n    <= 1'b1;
            rr_n     <= 1'b1;
            aq       <= 1'b1;
            cmd_done <= 1'b1;
            state    <= HBC_H_IDLE;
          end
        default:
          state <= HBC_H_IDLE;
      endcase
    end
  end

  assign link.bus_clk                = bclk;
  assign link.local_bus_select_n     = ~host_mode_local_bus;
  assign link.ready_return_n         = rr_n;
  assign link.read_strobe_n          = rd_n;
  assign link.write_strobe_n         = wr_n;
  assign link.address_qualifier      = aq;
  assign link.upper_address_bits     = addr;
  assign link.address_latch_strobe_n = ads_n;
  assign link.sync_cycle_n           = cyc_n;
  assign link.write_not_read         = wnr;

endmodule : hbc_host

/* File: dv/hbc_link_asserts.sv */
// Concurrent checks on the link between host and device ends
`timescale 1ns/1ns
module hbc_link_asserts
  import hbc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               arst_n,
  input wire logic               bus_clk,
  input wire logic               local_bus_select_n,
  input wire logic               ready_return_n,
  input wire logic               read_strobe_n,
  input wire logic               write_strobe_n,
  input wire logic               address_qualifier,
  input wire logic [ADDR_W-1:0]  upper_address_bits,
  input wire logic               sync_cycle_n,
  input wire logic               write_not_read,
  input wire logic               async_ready_out,
  input wire logic               sync_ready_n,
  input wire logic               host_irq,
  input wire logic               local_device_hit_n,
  input wire logic [BASE_W-1:0]  base_address_high,
  input wire logic [EVENT_W-1:0] irq_events,
  input wire logic [EVENT_W-1:0] irq_enable
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic strobe_on  = !read_strobe_n || !write_strobe_n;
  wire logic irq_any    = |(irq_events & irq_enable);
  wire logic addr_match = upper_address_bits == {base_address_high, BASE_LOW_NIBBLE};
  sequence s_strobes_idle;
    read_strobe_n && write_strobe_n;
  endsequence
  sequence s_ready_fall;
    $fell(sync_ready_n);
  endsequence
  // Ready return seen idle now and half a bus clock ago, so the device cannot have taken it yet
  sequence s_read_open;
    !sync_ready_n && !write_not_read && ready_return_n && $past(ready_return_n, 8);
  endsequence
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_hit_decode: assert property (local_device_hit_n == !(!address_qualifier && addr_match))
    else $error("hit output differs from address decode");
  a_irq_level: assert property (1'b1 |=> host_irq == $past(irq_any))
    else $error("interrupt does not follow enabled events");
  a_eisa_ready_quiet: assert property (local_bus_select_n |-> sync_ready_n)
    else $error("sync ready driven outside local-bus mode");
  a_ready_fall_clk: assert property (s_ready_fall |-> bus_clk)
    else $error("sync ready fell away from a bus clock rise");
  a_ready_low_span: assert property (s_ready_fall |-> !sync_ready_n [*8])
    else $error("sync ready low too short");
  a_read_waits_return: assert property (s_read_open |=> !sync_ready_n)
    else $error("sync read ended without ready return");
  a_async_rise_strobe: assert property ($rose(async_ready_out) |-> strobe_on)
    else $error("async ready rose with no access open");
  a_async_hold_strobe: assert property (!async_ready_out && strobe_on |=> strobe_on)
    else $error("strobe released while async ready low");
  a_async_idle_high: assert property (s_strobes_idle [*8] |-> async_ready_out)
    else $error("async ready low with no strobe");
  a_async_clk_high: assert property (strobe_on |-> bus_clk)
    else $error("bus clock low during async access");
  a_strobe_qualified: assert property (strobe_on |-> !address_qualifier)
    else $error("strobe without address qualifier");
  a_cycle_on_fall: assert property ($fell(sync_cycle_n) |-> !bus_clk)
    else $error("sync cycle not asserted on bus clock low phase");
  // Five samples per bus clock period is the fastest legal rate
  a_bus_clk_rate: assert property ($rose(bus_clk) |=> !$rose(bus_clk) [*4])
    else $error("bus clock faster than its limit");
endmodule : hbc_link_asserts

/* File: dv/host_bus_control_port_bench.sv */
// Bench joining host and device ends, acting as the device core
`timescale 1ns/1ns
module host_bus_control_port_bench;
  import hbc_pkg::*;
  logic               ref_clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               host_mode_async = 1'b1;
  logic               host_mode_local_bus = 1'b0;
  logic               cmd_valid = 1'b0;
  logic               cmd_write = 1'b0;
  logic               cmd_sync = 1'b0;
  logic [ADDR_W-1:0]  cmd_address = 12'h000;
  logic [BASE_W-1:0]  base_address_high = 8'h3c;
  logic [EVENT_W-1:0] irq_events = 8'h00;
  logic [EVENT_W-1:0] irq_enable = 8'h00;
  logic               acc_done = 1'b0;
  logic               cmd_ready, cmd_done, irq, acc_start, acc_write, acc_sync, mode_local_bus;
  logic               got_write, got_sync;
  logic [ADDR_W-1:0]  acc_address, got_address;
  logic [5:0]         tab [7];
  int                 n_errors = 0;
  int                 check_count = 0;
  int                 starts = 0;
  int                 core_delay = 1;

  always #(REF_PERIOD_NS / 2) ref_clk = ~ref_clk;

  hbc_link_if link();
  hbc_device u_hbc_device (.ref_clk(ref_clk), .arst_n(arst_n), .link(link),
    .base_address_high(base_address_high), .irq_events(irq_events), .irq_enable(irq_enable),
    .acc_done(acc_done), .acc_start(acc_start), .acc_write(acc_write), .acc_sync(acc_sync),
    .acc_address(acc_address), .mode_local_bus(mode_local_bus));
  hbc_host u_hbc_host (.ref_clk(ref_clk), .arst_n(arst_n), .link(link), .host_mode_async(host_mode_async),
    .host_mode_local_bus(host_mode_local_bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_sync(cmd_sync), .cmd_address(cmd_address), .cmd_done(cmd_done), .irq(irq));
  hbc_link_asserts u_hbc_link_asserts (.ref_clk(ref_clk), .arst_n(arst_n), .bus_clk(link.bus_clk),
    .local_bus_select_n(link.local_bus_select_n), .ready_return_n(link.ready_return_n),
    .read_strobe_n(link.read_strobe_n), .write_strobe_n(link.write_strobe_n),
    .address_qualifier(link.address_qualifier), .upper_address_bits(link.upper_address_bits),
    .sync_cycle_n(link.sync_cycle_n), .write_not_read(link.write_not_read),
    .async_ready_out(link.async_ready_out), .sync_ready_n(link.sync_ready_n), .host_irq(link.host_irq),
    .local_device_hit_n(link.local_device_hit_n), .base_address_high(base_address_high),
    .irq_events(irq_events), .irq_enable(irq_enable));

  // ----------------------------------------------------------------
  // Device core stand-in: answers each start after a set delay
  // ----------------------------------------------------------------
  initial
  begin
    forever
    begin
      @(posedge ref_clk);
      if (acc_start === 1'b1)
      begin
        starts++;
        got_write = acc_write;
        got_sync = acc_sync;
        got_address = acc_address;
        repeat (core_delay) @(posedge ref_clk);
        #1 acc_done = 1'b1;
        @(posedge ref_clk);
        #1 acc_done = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Mode pins are static levels: only changed once the host end is idle
  task automatic set_mode(input logic as, input logic lb);
    host_mode_async = as;
    host_mode_local_bus = lb;
    tick(20);
    check(16'(mode_local_bus), 16'(lb));
    check(16'(link.local_bus_select_n), 16'(!lb));
    if (as)
      check(16'(link.bus_clk), 16'h0001);
  endtask : set_mode

  task automatic do_cmd(input logic wr, input logic sy, input logic hit);
    int n;
    int s0;
    s0 = starts;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_sync = sy;
    cmd_address = {base_address_high, 3'h0, !hit};
    tick(1);
    cmd_valid = 1'b0;
    tick(2);
    check(16'(link.local_device_hit_n), 16'(!hit));
    n = 0;
    while (cmd_done !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    check(16'(n < 3000), 16'h0001);
    check(16'(starts - s0), 16'(hit));
    if (hit)
    begin
      check(16'(got_write), 16'(wr));
      check(16'(got_sync), 16'(sy && !host_mode_async));
      check(16'(got_address), 16'(cmd_address));
    end
  endtask : do_cmd

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    // Fields: async, local bus, write, sync, hit, slow core
    tab = '{6'b101011, 6'b110110, 6'b100000, 6'b010111, 6'b011110, 6'b000110, 6'b001111};
    tick(2);
    arst_n = 1'b1;
    tick(6);
    check(16'(link.sync_ready_n), 16'h0001);
    check(16'(link.async_ready_out), 16'h0001);
    check(16'(cmd_ready), 16'h0001);
    $display("test reset done, mismatches %0d", n_errors);
    for (int i = 0; i < 7; i++)
    begin
      if (tab[i][5] !== host_mode_async || tab[i][4] !== host_mode_local_bus || i == 0)
        set_mode(tab[i][5], tab[i][4]);
      core_delay = tab[i][0] ? 30 : 1;
      do_cmd(tab[i][3], tab[i][2], tab[i][1]);
      $display("test access %0d done, mismatches %0d", i, n_errors);
    end
    irq_events = 8'h05;
    irq_enable = 8'h0a;
    tick(10);
    check(16'(link.host_irq), 16'h0000);
    irq_enable = 8'h04;
    tick(10);
    check(16'(link.host_irq), 16'h0001);
    check(16'(irq), 16'h0001);
    irq_events = 8'h01;
    tick(10);
    check(16'(irq), 16'h0000);
    $display("test interrupt done, mismatches %0d", n_errors);
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
endmodule : host_bus_control_port_bench
